// ==== src/epci_map.vh ====
`ifndef EPCI_MAP_VH
`define EPCI_MAP_VH

// Register indices; byte address is four times the index
`define EPCI_IDX_ENABLE_MASK 6'h10
`define EPCI_IDX_FLAGS 6'h11
`define EPCI_IDX_MASK_LOW 6'h12
`define EPCI_IDX_MASK_HIGH 6'h13
`define EPCI_IDX_EXT_CTRL 6'h14

// Field positions in interrupt_enable_mask and interrupt_flags
`define EPCI_BIT_EXT 6
`define EPCI_BIT_GRP1 5
`define EPCI_BIT_GRP0 4

// Writable and readable bits per register
`define EPCI_EN_MASK_BITS 8'h70
`define EPCI_FLAG_BITS 8'h70
`define EPCI_MASK_HIGH_BITS 8'h0F
`define EPCI_EXT_CTRL_BITS 8'h03

// Reset values
`define EPCI_RST_ENABLE_MASK 8'h00
`define EPCI_RST_FLAGS 8'h00
`define EPCI_RST_MASK_LOW 8'h00
`define EPCI_RST_MASK_HIGH 8'h00
`define EPCI_RST_EXT_CTRL 2'h0

// Sense select codes
`define EPCI_SENSE_LOW 2'h0
`define EPCI_SENSE_ANY 2'h1
`define EPCI_SENSE_FALL 2'h2
`define EPCI_SENSE_RISE 2'h3

// Vector request bit positions
`define EPCI_VEC_EXT 0
`define EPCI_VEC_GRP0 1
`define EPCI_VEC_GRP1 2

// Cycles after reset before the edge detectors trust their history
`define EPCI_PRIME_CYCLES 2'h3

`endif

// ==== src/epci_irq_top.v ====
// Notes on behaviour
// - External pin interrupt enabled only when its enable bit and global enable set.
// - Pin activity requests interrupts even when the pin drives as an output.
// - Group 1 enable plus global enable: unmasked change on inputs 11..8 requests.
// - Group 0 enable plus global enable: unmasked change on inputs 7..0 requests.
// - External pin flag sets when an edge or change on the pin triggers.
// - Group 1 flag sets on a change of any unmasked input 11..8.
// - Group 0 flag sets on a change of any unmasked input 7..0.
// - Flag set with its enable and global enable raises the matching vector.
// - Flags clear on vector service or on writing one; zero writes do nothing.
// - In low-level mode the external pin flag stays cleared.
// - Flag register bits 7 and 3..0 read as zero.
// - High mask bits 3..0 gate inputs 11..8; bits 7..4 read zero.
// - Low mask at index 0x12, eight read/write bits, reset zero, gates inputs 7..0.
// - Sense select: 00 low level, 01 any change, 10 falling, 11 rising.
// - Pulses longer than one clock are caught; shorter ones are not guaranteed.
// - Pin change and low level also detected without clock, for wake-up.
// - Low-level mode keeps requesting while the pin stays low.
//
// Added by the designer: the Wishbone interface to the registers.
`include "epci_map.vh"

module epci_irq_top #(
   parameter NUM_PC_LOW = 8,
   parameter NUM_PC_HIGH = 4
) (
   // Clock, reset, enable
   input wire I_SYS_CLK,
   input wire I_RESET_N,
   input wire I_CLK_EN,
   // Wishbone slave
   input wire I_WB_CYC,
   input wire I_WB_STB,
   input wire I_WB_WE,
   input wire [7:0] I_WB_ADR,
   input wire [3:0] I_WB_SEL,
   input wire [31:0] I_WB_DAT,
   output wire [31:0] O_WB_DAT,
   output wire O_WB_ACK,
   // Pins
   input wire I_EXT_PIN_IRQ_ZERO,
   input wire [NUM_PC_LOW-1:0] I_PINCHG_INPUTS_LOW,
   input wire [NUM_PC_HIGH-1:0] I_PINCHG_INPUTS_HIGH,
   // CPU side
   input wire I_GLOBAL_IE,
   input wire [2:0] I_VEC_SERVED,
   output wire [2:0] O_VEC_REQ,
   output wire O_IRQ,
   output wire O_WAKE
);

   localparam NUM_PC = NUM_PC_LOW + NUM_PC_HIGH;
   localparam NUM_IN = NUM_PC + 1;

   // Register state
   reg [7:0] interrupt_enable_mask;
   reg [7:0] interrupt_flags;
   reg [7:0] pin_change_mask_low;
   reg [7:0] pin_change_mask_high;
   reg [1:0] ext_irq_control;
   reg ack;
   reg [7:0] rd_data;

   // Synchroniser and history
   reg [NUM_IN-1:0] sync_meta;
   reg [NUM_IN-1:0] sync_pin;
   reg [NUM_IN-1:0] prev_pin;
   reg [1:0] prime_cnt;
   wire primed;

   wire [NUM_IN-1:0] raw_in;
   wire [NUM_IN-1:0] pin_changed;
   wire [NUM_PC-1:0] pc_mask;
   wire [NUM_PC-1:0] pc_hit;
   wire grp0_event;
   wire grp1_event;
   wire ext_pin;
   wire ext_prev;
   wire ext_level_mode;
   reg ext_event;

   // Bus decode
   wire [5:0] reg_idx;
   wire bus_req;
   wire wr_stb;
   wire wr_en_mask;
   wire wr_flags;
   wire wr_mask_low;
   wire wr_mask_high;
   wire wr_ext_ctrl;

   // Flag updates
   reg [7:0] next_interrupt_flags;
   wire [7:0] flag_set;
   wire [7:0] flag_clr;
   wire [7:0] flag_read;

   // Request gating
   wire gate_ext;
   wire gate_grp0;
   wire gate_grp1;
   wire ext_req;

   assign raw_in = {I_PINCHG_INPUTS_HIGH, I_PINCHG_INPUTS_LOW, I_EXT_PIN_IRQ_ZERO};
   assign pc_mask = {pin_change_mask_high[NUM_PC_HIGH-1:0],
                     pin_change_mask_low[NUM_PC_LOW-1:0]};
   assign primed = (prime_cnt == `EPCI_PRIME_CYCLES);

   // Pins are sampled whatever their direction, so software driving them can trigger
   always @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         sync_meta <= {NUM_IN{1'b0}};
         sync_pin <= {NUM_IN{1'b0}};
         prev_pin <= {NUM_IN{1'b0}};
         prime_cnt <= 2'h0;
      end else if (I_CLK_EN) begin
         sync_meta <= raw_in;
         sync_pin <= sync_meta;
         prev_pin <= sync_pin;
         if (!primed) begin
            prime_cnt <= prime_cnt + 2'h1;
         end
      end
   end

   // History is zero after reset; detection waits until it holds real samples
   genvar g;
   generate
      for (g = 0; g < NUM_IN; g = g + 1) begin : g_detect
         assign pin_changed[g] = primed & (sync_pin[g] ^ prev_pin[g]);
      end
      for (g = 0; g < NUM_PC; g = g + 1) begin : g_mask
         assign pc_hit[g] = pin_changed[g+1] & pc_mask[g];
      end
   endgenerate

   assign grp0_event = |pc_hit[NUM_PC_LOW-1:0];
   assign grp1_event = |pc_hit[NUM_PC-1:NUM_PC_LOW];

   assign ext_pin = sync_pin[0];
   assign ext_prev = prev_pin[0];
   assign ext_level_mode = (ext_irq_control == `EPCI_SENSE_LOW);

   always @* begin
      case (ext_irq_control)
         `EPCI_SENSE_ANY: ext_event = pin_changed[0];
         `EPCI_SENSE_FALL: ext_event = primed & ext_prev & ~ext_pin;
         `EPCI_SENSE_RISE: ext_event = primed & ~ext_prev & ext_pin;
         default: ext_event = 1'b0;
      endcase
   end

   // Bus: one registered ack per request, unmapped indices read zero
   assign reg_idx = I_WB_ADR[7:2];
   assign bus_req = I_WB_CYC & I_WB_STB & ~ack;
   // Writes land on the edge that also sees ack, while the master still holds the request
   assign wr_stb = I_WB_CYC & I_WB_STB & ack & I_WB_WE & I_WB_SEL[0] & I_CLK_EN;
   assign wr_en_mask = wr_stb & (reg_idx == `EPCI_IDX_ENABLE_MASK);
   assign wr_flags = wr_stb & (reg_idx == `EPCI_IDX_FLAGS);
   assign wr_mask_low = wr_stb & (reg_idx == `EPCI_IDX_MASK_LOW);
   assign wr_mask_high = wr_stb & (reg_idx == `EPCI_IDX_MASK_HIGH);
   assign wr_ext_ctrl = wr_stb & (reg_idx == `EPCI_IDX_EXT_CTRL);

   // Flags are edge captured, so the set holds even if enables are off
   assign flag_set[`EPCI_BIT_EXT] = ext_event & ~ext_level_mode;
   assign flag_set[`EPCI_BIT_GRP1] = grp1_event;
   assign flag_set[`EPCI_BIT_GRP0] = grp0_event;
   assign flag_set[7] = 1'b0;
   assign flag_set[3:0] = 4'h0;

   assign flag_clr[`EPCI_BIT_EXT] = I_VEC_SERVED[`EPCI_VEC_EXT];
   assign flag_clr[`EPCI_BIT_GRP1] = I_VEC_SERVED[`EPCI_VEC_GRP1];
   assign flag_clr[`EPCI_BIT_GRP0] = I_VEC_SERVED[`EPCI_VEC_GRP0];
   assign flag_clr[7] = 1'b0;
   assign flag_clr[3:0] = 4'h0;

   always @* begin
      next_interrupt_flags = interrupt_flags & ~flag_clr;
      if (wr_flags) begin
         next_interrupt_flags = next_interrupt_flags & ~I_WB_DAT[7:0];
      end
      // A new event in the clearing cycle wins over the clear
      next_interrupt_flags = (next_interrupt_flags | flag_set) & `EPCI_FLAG_BITS;
      if (ext_level_mode) begin
         next_interrupt_flags[`EPCI_BIT_EXT] = 1'b0;
      end
   end

   always @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         interrupt_enable_mask <= `EPCI_RST_ENABLE_MASK;
         interrupt_flags <= `EPCI_RST_FLAGS;
         pin_change_mask_low <= `EPCI_RST_MASK_LOW;
         pin_change_mask_high <= `EPCI_RST_MASK_HIGH;
         ext_irq_control <= `EPCI_RST_EXT_CTRL;
      end else if (I_CLK_EN) begin
         interrupt_flags <= next_interrupt_flags;
         if (wr_en_mask) begin
            interrupt_enable_mask <= I_WB_DAT[7:0] & `EPCI_EN_MASK_BITS;
         end
         if (wr_mask_low) begin
            pin_change_mask_low <= I_WB_DAT[7:0];
         end
         if (wr_mask_high) begin
            pin_change_mask_high <= I_WB_DAT[7:0] & `EPCI_MASK_HIGH_BITS;
         end
         if (wr_ext_ctrl) begin
            ext_irq_control <= I_WB_DAT[1:0];
         end
      end
   end

   assign flag_read = interrupt_flags & `EPCI_FLAG_BITS;

   always @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         ack <= 1'b0;
         rd_data <= 8'h00;
      end else if (I_CLK_EN) begin
         ack <= bus_req;
         if (bus_req) begin
            case (reg_idx)
               `EPCI_IDX_ENABLE_MASK: rd_data <= interrupt_enable_mask;
               `EPCI_IDX_FLAGS: rd_data <= flag_read;
               `EPCI_IDX_MASK_LOW: rd_data <= pin_change_mask_low;
               `EPCI_IDX_MASK_HIGH: rd_data <= pin_change_mask_high;
               `EPCI_IDX_EXT_CTRL: rd_data <= {6'h00, ext_irq_control};
               default: rd_data <= 8'h00;
            endcase
         end
      end
   end

   assign O_WB_ACK = ack;
   assign O_WB_DAT = {24'h00_0000, rd_data};

   // Requests need the per-source enable and the global enable
   assign gate_ext = I_GLOBAL_IE & interrupt_enable_mask[`EPCI_BIT_EXT];
   assign gate_grp0 = I_GLOBAL_IE & interrupt_enable_mask[`EPCI_BIT_GRP0];
   assign gate_grp1 = I_GLOBAL_IE & interrupt_enable_mask[`EPCI_BIT_GRP1];

   // Level mode bypasses the flag and requests for as long as the pin is low
   assign ext_req = ext_level_mode ? (primed & ~ext_pin)
                                   : interrupt_flags[`EPCI_BIT_EXT];

   assign O_VEC_REQ[`EPCI_VEC_EXT] = gate_ext & ext_req;
   assign O_VEC_REQ[`EPCI_VEC_GRP0] = gate_grp0 & interrupt_flags[`EPCI_BIT_GRP0];
   assign O_VEC_REQ[`EPCI_VEC_GRP1] = gate_grp1 & interrupt_flags[`EPCI_BIT_GRP1];
   assign O_IRQ = |O_VEC_REQ;

   // Clockless wake path: raw pins against the last clocked sample. Glitchy by
   // nature; it only starts the clock, the flags are set by the synchronised path.
   assign O_WAKE = (interrupt_enable_mask[`EPCI_BIT_EXT] & ext_level_mode
                    & ~I_EXT_PIN_IRQ_ZERO)
                 | (interrupt_enable_mask[`EPCI_BIT_GRP0]
                    & |((I_PINCHG_INPUTS_LOW ^ sync_pin[NUM_PC_LOW:1])
                        & pc_mask[NUM_PC_LOW-1:0]))
                 | (interrupt_enable_mask[`EPCI_BIT_GRP1]
                    & |((I_PINCHG_INPUTS_HIGH ^ sync_pin[NUM_PC:NUM_PC_LOW+1])
                        & pc_mask[NUM_PC-1:NUM_PC_LOW]));

endmodule // epci_irq_top

// ==== tb/epci_irq_props.sv ====
module epci_irq_props #(
   parameter NUM_PC_LOW = 8,
   parameter NUM_PC_HIGH = 4
) (
   // Bus side
   input logic I_SYS_CLK,
   input logic I_RESET_N,
   input logic I_CLK_EN,
   input logic I_WB_CYC,
   input logic I_WB_STB,
   input logic I_WB_WE,
   input logic [7:0] I_WB_ADR,
   input logic [31:0] O_WB_DAT,
   input logic O_WB_ACK,
   // Pin and CPU side
   input logic I_EXT_PIN_IRQ_ZERO,
   input logic [NUM_PC_LOW-1:0] I_PINCHG_INPUTS_LOW,
   input logic [NUM_PC_HIGH-1:0] I_PINCHG_INPUTS_HIGH,
   input logic I_GLOBAL_IE,
   input logic [2:0] I_VEC_SERVED,
   input logic [2:0] O_VEC_REQ,
   input logic O_IRQ
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RESET_N);
   AST_ACK: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK && I_CLK_EN
      |=> O_WB_ACK) else $error("no ack");
   AST_ACK_ONE: assert property (O_WB_ACK && I_CLK_EN |=> !O_WB_ACK)
      else $error("ack too long");
   AST_IRQ_OR: assert property (O_IRQ == |O_VEC_REQ) else $error("irq mismatch");
   AST_NO_GIE: assert property (!I_GLOBAL_IE |-> O_VEC_REQ == 3'h0)
      else $error("request while global enable low");
   AST_FLAG_RES: assert property (O_WB_ACK && $past(I_WB_ADR) == 8'h44 && !$past(I_WB_WE)
      |-> (O_WB_DAT & 32'hffff_ff8f) == 32'h0000_0000) else $error("flag reserved set");
   AST_MASKH_RES: assert property (O_WB_ACK && $past(I_WB_ADR) == 8'h4c && !$past(I_WB_WE)
      |-> (O_WB_DAT & 32'hffff_fff0) == 32'h0000_0000) else $error("mask reserved set");
   // Settled pins rule out a same-cycle event, which would legally win over the service
   AST_SERVE_CLR: assert property (
      ($stable({I_PINCHG_INPUTS_HIGH, I_PINCHG_INPUTS_LOW}))[*4] ##0 I_VEC_SERVED[1] && I_CLK_EN
      |=> !O_VEC_REQ[1]) else $error("served request stays");
   AST_REQ_HOLD: assert property (
      ($stable({I_EXT_PIN_IRQ_ZERO, I_PINCHG_INPUTS_HIGH, I_PINCHG_INPUTS_LOW}) && !I_WB_CYC
      && I_VEC_SERVED == 3'h0 && $stable(I_GLOBAL_IE))[*4] |-> $stable(O_VEC_REQ))
      else $error("request moved while quiet");
endmodule // epci_irq_props
bind epci_irq_top epci_irq_props #(.NUM_PC_LOW(NUM_PC_LOW), .NUM_PC_HIGH(NUM_PC_HIGH))
   epci_irq_props_inst (.I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N), .I_CLK_EN(I_CLK_EN),
   .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
   .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_EXT_PIN_IRQ_ZERO(I_EXT_PIN_IRQ_ZERO),
   .I_PINCHG_INPUTS_LOW(I_PINCHG_INPUTS_LOW), .I_PINCHG_INPUTS_HIGH(I_PINCHG_INPUTS_HIGH),
   .I_GLOBAL_IE(I_GLOBAL_IE), .I_VEC_SERVED(I_VEC_SERVED), .O_VEC_REQ(O_VEC_REQ), .O_IRQ(O_IRQ));

// ==== tb/epci_pin_model.sv ====
module epci_pin_model (
   // Clock and wanted levels
   input logic clk,
   input logic [12:0] want,
   input logic [1:0] lag,
   // Pin levels, idle high as if pulled up
   output logic [12:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0][12:0] dly = {4{13'h1fff}};
   initial pins = 13'h1fff;
   always @(posedge clk) dly <= {dly[2:0], want};
   // Levels move mid-cycle and last whole clocks: no pulse is shorter than a period
   always @(negedge clk) pins <= dly[lag];
endmodule // epci_pin_model

// ==== tb/epci_irq_top_bench.sv ====
`include "epci_map.vh"
module epci_irq_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, gie = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000, q;
   logic [2:0] srv = 3'h0;
   logic [12:0] want = 13'h1fff, cur = 13'h1fff;
   logic [1:0] lag = 2'h0;
   logic [15:0] lf = 16'd10602;
   logic [7:0] acc [6] = '{8'h70, 8'h00, 8'hff, 8'h0f, 8'h03, 8'h00};
   wire [31:0] rdat;
   wire [2:0] req;
   wire [11:0] pc;
   wire ack, irq, ext, wake;
   int error_cnt = 0, samples_checked = 0, fl, en, ml, mh, sc;
   always #5 clk = ~clk;
   epci_pin_model epci_pin_model_inst (.clk(clk), .want(want), .lag(lag), .pins({ext, pc}));
   epci_irq_top epci_irq_top_inst (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_CLK_EN(1'b1),
      .I_WB_CYC(cyc), .I_WB_STB(cyc), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'h1),
      .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_EXT_PIN_IRQ_ZERO(ext),
      .I_PINCHG_INPUTS_LOW(pc[7:0]), .I_PINCHG_INPUTS_HIGH(pc[11:8]), .I_GLOBAL_IE(gie),
      .I_VEC_SERVED(srv), .O_VEC_REQ(req), .O_IRQ(irq), .O_WAKE(wake));
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
      int n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      wdat <= {24'h00_0000, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      cyc <= 1'b0;
      q = rdat;
      if (n >= 50) begin
         error_cnt++;
         close_out;
      end else if (w) begin
         case (i)
            `EPCI_IDX_ENABLE_MASK: en = d & 8'h70;
            `EPCI_IDX_FLAGS: fl &= ~(d & 8'h70);
            `EPCI_IDX_MASK_LOW: ml = d;
            `EPCI_IDX_MASK_HIGH: mh = d & 8'h0f;
            `EPCI_IDX_EXT_CTRL: sc = d & 8'h03;
            default: ;
         endcase
         if (sc == 0) fl &= 32'h0000_00bf;
      end
   endtask
   // The longest pin lag plus the three-edge detection path fits well inside ten cycles
   task automatic pins(input logic [12:0] v);
      logic [12:0] ch;
      ch = cur ^ v;
      want <= v;
      repeat (10) @(posedge clk);
      if ((ch[7:0] & ml[7:0]) != 8'h00) fl |= 32'h0000_0010;
      if ((ch[11:8] & mh[3:0]) != 4'h0) fl |= 32'h0000_0020;
      if (sc != 0 && ch[12] && (sc == 1 || v[12] == sc[0])) fl |= 32'h0000_0040;
      cur = v;
   endtask
   task automatic look;
      logic [2:0] e;
      bus(1'b0, `EPCI_IDX_FLAGS, 8'h00);
      chk("flags", fl, q);
      e[0] = en[6] && (sc == 0 ? !cur[12] : fl[6]);
      e[1] = en[4] && fl[4];
      e[2] = en[5] && fl[5];
      e = gie ? e : 3'h0;
      chk("vec_req", e, req);
      chk("irq", e != 3'h0, irq);
      chk("wake", en[6] && sc == 0 && !cur[12], wake);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 16; i <= 21; i++) begin
         bus(1'b0, i[5:0], 8'h00);
         chk("reset", 0, q);
         bus(1'b1, i[5:0], 8'hff);
         bus(1'b0, i[5:0], 8'h00);
         chk("access", acc[i - 16], q);
      end
      for (int k = 0; k < 24; k++) begin
         lf = nx(lf);
         bus(1'b1, `EPCI_IDX_ENABLE_MASK, lf[7:0]);
         bus(1'b1, `EPCI_IDX_MASK_LOW, lf[15:8]);
         lf = nx(lf);
         bus(1'b1, `EPCI_IDX_MASK_HIGH, lf[7:0]);
         bus(1'b1, `EPCI_IDX_EXT_CTRL, k[7:0]);
         gie <= lf[8];
         lag <= lf[10:9];
         lf = nx(lf);
         pins(lf[12:0]);
         look;
         lf = nx(lf);
         if (k[0]) bus(1'b1, `EPCI_IDX_FLAGS, lf[7:0]);
         else begin
            srv <= lf[2:0];
            @(posedge clk);
            srv <= 3'h0;
            fl &= ~{lf[0], lf[2], lf[1], 4'h0};
         end
         look;
      end
      close_out;
   end
endmodule // epci_irq_top_bench
